// *** hdl/lcdcd_cfg.svh ***
// constants for the lcd command decoder: opcodes, masks, fields, offsets, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH

// command opcodes and compare masks
`define LCDCD_M_FULL      8'hFF
`define LCDCD_M_BIT0      8'hFE
`define LCDCD_M_LOW3      8'hF8
`define LCDCD_M_NIB       8'hF0
`define LCDCD_M_LOW6      8'hC0
`define LCDCD_OP_DISP     8'hAE
`define LCDCD_OP_REV      8'hA6
`define LCDCD_OP_ALLON    8'hA4
`define LCDCD_OP_BIAS     8'hA2
`define LCDCD_OP_RMW      8'hE0
`define LCDCD_OP_END      8'hEE
`define LCDCD_OP_RESET    8'hE2
`define LCDCD_OP_NOP      8'hE3
`define LCDCD_OP_OSC      8'hE4
`define LCDCD_OP_SCAN     8'hC0
`define LCDCD_OP_PWR      8'h28
`define LCDCD_OP_RATIO    8'h20
`define LCDCD_OP_VOL      8'h81
`define LCDCD_OP_IND      8'hAC
`define LCDCD_OP_PART     8'h82
`define LCDCD_OP_START    8'h40
`define LCDCD_OP_PAGE     8'hB0
`define LCDCD_OP_COLH     8'h10
`define LCDCD_OP_COLL     8'h00
`define LCDCD_OP_TEST     8'hF0

// field positions inside command bytes
`define LCDCD_FLAG_BIT    0
`define LCDCD_SCAN_BIT    3
`define LCDCD_FOLLOW_BIT  0
`define LCDCD_REGUL_BIT   1
`define LCDCD_BOOST_BIT   2

// reset values
`define LCDCD_VOL_RST     6'h00
`define LCDCD_RATIO_RST   3'h0
`define LCDCD_PWR_RST     3'h0
`define LCDCD_IND_RST     2'h0
`define LCDCD_COL_RST     8'h00
`define LCDCD_COL_MAX     8'h83
`define LCDCD_PAGE_RST    4'h0
`define LCDCD_LINE_RST    6'h00

// indicator drive codes
`define LCDCD_IND_OFF     2'h0
`define LCDCD_IND_FAST    2'h1
`define LCDCD_IND_SLOW    2'h2
`define LCDCD_IND_STEADY  2'h3

// apb register byte offsets
`define LCDCD_REG_CTRL    12'h000
`define LCDCD_REG_STATUS  12'h004
`define LCDCD_REG_SETUP   12'h008
`define LCDCD_REG_ADDR    12'h00C
`define LCDCD_CTRL_RDSTB  0

// timing
`define LCDCD_CLK_KHZ     50000
`define LCDCD_BLINK_FAST_MS 500
`define LCDCD_BLINK_SLOW_MS 1000

`endif

// *** hdl/lcdcd_pkg.sv ***
// types shared by the lcd command decoder modules
// assumes lcdcd_cfg.svh sits beside this file
`include "lcdcd_cfg.svh"
package lcdcd_pkg;
	typedef logic [7:0] lcdcd_byte_t;
	typedef enum logic [1:0] {
		PS_ACTIVE,
		PS_STANDBY,
		PS_SLEEP
	} lcdcd_psave_e;
endpackage

// *** hdl/lcdcd_serial_rx.sv ***
// serial byte receiver of the lcd command decoder
// assumes clock, data, select and command/data line come asynchronously from the host
`timescale 1ns/100ps
`include "lcdcd_cfg.svh"
module lcdcd_serial_rx
	import lcdcd_pkg::*;
#(
	parameter int BITS = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        chip_sel_n,
	input  wire logic        cmd_data_select,
	output logic             byte_valid,
	output lcdcd_byte_t      byte_data,
	output logic             byte_is_cmd
);
	logic [3:0]      sync_a;
	logic [3:0]      sync_b;
	logic            clk_prev;
	logic [BITS-2:0] shift;
	logic [2:0]      count;
	logic            rise;

	// two-stage synchroniser for all host pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 4'h2;
			sync_b <= 4'h2;
		end else begin
			sync_a <= {cmd_data_select, serial_data, chip_sel_n, serial_clk};
			sync_b <= sync_a;
		end
	end

	// rising edge of the link clock, found on the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= sync_b[0];
		end
	end
	assign rise = sync_b[0] & ~clk_prev;

	// msb-first shift; deselect restarts the byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift       <= '0;
			count       <= 3'h0;
			byte_valid  <= 1'b0;
			byte_data   <= 8'h00;
			byte_is_cmd <= 1'b0;
		end else begin
			byte_valid <= 1'b0;
			if (sync_b[1]) begin
				count <= 3'h0;
			end else if (rise) begin
				shift <= {shift[BITS-3:0], sync_b[2]};
				count <= count + 3'h1;
				if (count == 3'(BITS - 1)) begin
					byte_valid  <= 1'b1;
					byte_data   <= {shift, sync_b[2]};
					byte_is_cmd <= ~sync_b[3];
				end
			end
		end
	end
endmodule

// *** hdl/lcdcd_top.sv ***
// lcd command decoder: serial command interpreter with apb status and control
// assumes host serial pins and hardware reset pin are asynchronous to pclk
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "lcdcd_cfg.svh"
module lcdcd_top
	import lcdcd_pkg::*;
#(
	parameter int FAST_CYC = `LCDCD_BLINK_FAST_MS * `LCDCD_CLK_KHZ,
	parameter int SLOW_CYC = `LCDCD_BLINK_SLOW_MS * `LCDCD_CLK_KHZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_reset_n,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        chip_sel_n,
	input  wire logic        cmd_data_select,
	input  wire logic        duty_strap_lo,
	input  wire logic        duty_strap_hi,
	input  wire logic        ram_bit,
	output logic             pixel_drive,
	output logic             drive_active,
	output logic             osc_run,
	output logic             osc_slow,
	output logic             follower_en,
	output logic             regulator_en,
	output logic             booster_en,
	output logic             bias_seventh,
	output logic             scan_reverse,
	output logic [2:0]       reg_ratio,
	output logic [5:0]       volume,
	output logic             indicator_segment_terminal,
	output logic             partial_mode,
	output logic [1:0]       max_duty,
	output logic [7:0]       column,
	output logic [3:0]       page,
	output logic [5:0]       start_line
);
	lcdcd_byte_t  rx_data;
	logic         rx_valid;
	logic         rx_cmd;
	logic [1:0]   hw_sync;
	logic [1:0]   strap_a;
	logic         hw_init;
	logic         cmd_go;
	logic         data_go;
	logic         soft_rst;
	logic         disp_on;
	logic         reverse;
	logic         all_on;
	logic         ind_on;
	logic [1:0]   ind_mode;
	logic         vol_pending;
	logic         ind_pending;
	logic         rmw;
	logic [7:0]   rmw_col;
	logic         test_mode;
	logic [2:0]   power_ctl;
	logic         force_sleep;
	logic         rd_strobe;
	logic         power_save;
	lcdcd_psave_e next_ps;
	lcdcd_psave_e ps;
	logic [31:0]  blink_cnt;
	logic         blink_fast;
	logic         blink_slow;
	logic         apb_setup;
	logic         apb_wr;

	// opcode compare under a mask
	function automatic logic op_is(input lcdcd_byte_t b, input lcdcd_byte_t op, input lcdcd_byte_t m);
		op_is = ((b & m) == op);
	endfunction

	// next column with wrap past the last address
	function automatic logic [7:0] col_step(input logic [7:0] c);
		col_step = (c == `LCDCD_COL_MAX) ? `LCDCD_COL_RST : c + 8'h01;
	endfunction

	lcdcd_serial_rx #(
		.BITS            (8)
	) u_rx (
		.pclk            (pclk),
		.presetn         (presetn),
		.serial_clk      (serial_clk),
		.serial_data     (serial_data),
		.chip_sel_n      (chip_sel_n),
		.cmd_data_select (cmd_data_select),
		.byte_valid      (rx_valid),
		.byte_data       (rx_data),
		.byte_is_cmd     (rx_cmd)
	);

	// hardware reset pin and duty straps pass two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_sync  <= 2'h0;
			strap_a  <= 2'h0;
			max_duty <= 2'h0;
		end else begin
			hw_sync  <= {hw_sync[0], hw_reset_n};
			strap_a  <= {duty_strap_hi, duty_strap_lo};
			max_duty <= strap_a;
		end
	end
	assign hw_init = ~hw_sync[1];

	// pending second bytes swallow the next command byte
	assign cmd_go   = rx_valid & rx_cmd & ~vol_pending & ~ind_pending;
	assign data_go  = rx_valid & ~rx_cmd;
	assign soft_rst = cmd_go & op_is(rx_data, `LCDCD_OP_RESET, `LCDCD_M_FULL);

	// display flags and single-byte settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_on      <= 1'b0;
			reverse      <= 1'b0;
			all_on       <= 1'b0;
			bias_seventh <= 1'b0;
			osc_slow     <= 1'b0;
			partial_mode <= 1'b0;
		end else if (hw_init) begin
			disp_on      <= 1'b0;
			reverse      <= 1'b0;
			all_on       <= 1'b0;
			bias_seventh <= 1'b0;
			osc_slow     <= 1'b0;
			partial_mode <= 1'b0;
		end else if (cmd_go) begin
			if (op_is(rx_data, `LCDCD_OP_DISP, `LCDCD_M_BIT0))
				disp_on <= rx_data[`LCDCD_FLAG_BIT];
			if (op_is(rx_data, `LCDCD_OP_REV, `LCDCD_M_BIT0))
				reverse <= rx_data[`LCDCD_FLAG_BIT];
			if (op_is(rx_data, `LCDCD_OP_ALLON, `LCDCD_M_BIT0))
				all_on <= rx_data[`LCDCD_FLAG_BIT];
			if (op_is(rx_data, `LCDCD_OP_BIAS, `LCDCD_M_BIT0))
				bias_seventh <= rx_data[`LCDCD_FLAG_BIT];
			if (op_is(rx_data, `LCDCD_OP_OSC, `LCDCD_M_BIT0))
				osc_slow <= rx_data[`LCDCD_FLAG_BIT];
			if (op_is(rx_data, `LCDCD_OP_PART, `LCDCD_M_BIT0))
				partial_mode <= rx_data[`LCDCD_FLAG_BIT];
		end
	end

	// power circuit field survives software reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_ctl <= `LCDCD_PWR_RST;
		end else if (hw_init) begin
			power_ctl <= `LCDCD_PWR_RST;
		end else if (cmd_go && op_is(rx_data, `LCDCD_OP_PWR, `LCDCD_M_LOW3)) begin
			power_ctl <= rx_data[2:0];
		end
	end

	// settings cleared by software reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_reverse <= 1'b0;
			reg_ratio    <= `LCDCD_RATIO_RST;
			volume       <= `LCDCD_VOL_RST;
			ind_mode     <= `LCDCD_IND_RST;
			test_mode    <= 1'b0;
			start_line   <= `LCDCD_LINE_RST;
			page         <= `LCDCD_PAGE_RST;
		end else if (hw_init || soft_rst) begin
			scan_reverse <= 1'b0;
			reg_ratio    <= `LCDCD_RATIO_RST;
			volume       <= `LCDCD_VOL_RST;
			ind_mode     <= `LCDCD_IND_RST;
			test_mode    <= 1'b0;
			start_line   <= `LCDCD_LINE_RST;
			page         <= `LCDCD_PAGE_RST;
		end else if (rx_valid && rx_cmd && vol_pending) begin
			volume <= rx_data[5:0];
		end else if (rx_valid && rx_cmd && ind_pending) begin
			ind_mode <= rx_data[1:0];
		end else if (cmd_go) begin
			if (op_is(rx_data, `LCDCD_OP_SCAN, `LCDCD_M_NIB))
				scan_reverse <= rx_data[`LCDCD_SCAN_BIT];
			if (op_is(rx_data, `LCDCD_OP_RATIO, `LCDCD_M_LOW3))
				reg_ratio <= rx_data[2:0];
			if (op_is(rx_data, `LCDCD_OP_START, `LCDCD_M_LOW6))
				start_line <= rx_data[5:0];
			if (op_is(rx_data, `LCDCD_OP_PAGE, `LCDCD_M_NIB))
				page <= rx_data[3:0];
			if (op_is(rx_data, `LCDCD_OP_TEST, `LCDCD_M_NIB))
				test_mode <= (rx_data != `LCDCD_OP_TEST);
		end
	end

	// two-byte command locks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vol_pending <= 1'b0;
			ind_pending <= 1'b0;
			ind_on      <= 1'b0;
		end else if (hw_init) begin
			vol_pending <= 1'b0;
			ind_pending <= 1'b0;
			ind_on      <= 1'b0;
		end else if (rx_valid && rx_cmd && (vol_pending || ind_pending)) begin
			vol_pending <= 1'b0;
			ind_pending <= 1'b0;
		end else if (cmd_go) begin
			if (op_is(rx_data, `LCDCD_OP_VOL, `LCDCD_M_FULL))
				vol_pending <= 1'b1;
			if (op_is(rx_data, `LCDCD_OP_IND, `LCDCD_M_BIT0)) begin
				ind_on      <= rx_data[`LCDCD_FLAG_BIT];
				ind_pending <= rx_data[`LCDCD_FLAG_BIT];
			end
		end
	end

	// column counter with read-modify-write save and restore
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			column  <= `LCDCD_COL_RST;
			rmw     <= 1'b0;
			rmw_col <= `LCDCD_COL_RST;
		end else if (hw_init || soft_rst) begin
			column <= `LCDCD_COL_RST;
			rmw    <= 1'b0;
		end else if (cmd_go && op_is(rx_data, `LCDCD_OP_RMW, `LCDCD_M_FULL)) begin
			rmw     <= 1'b1;
			rmw_col <= column;
		end else if (cmd_go && op_is(rx_data, `LCDCD_OP_END, `LCDCD_M_FULL)) begin
			rmw <= 1'b0;
			if (rmw)
				column <= rmw_col;
		end else if (cmd_go && op_is(rx_data, `LCDCD_OP_COLH, `LCDCD_M_NIB)) begin
			column <= {rx_data[3:0], column[3:0]};
		end else if (cmd_go && op_is(rx_data, `LCDCD_OP_COLL, `LCDCD_M_NIB)) begin
			column <= {column[7:4], rx_data[3:0]};
		end else if (data_go || (rd_strobe && !rmw)) begin
			column <= col_step(column);
		end
	end

	// power save selection: sleep or standby
	assign power_save = ~disp_on & all_on;
	always_comb begin
		next_ps = PS_ACTIVE;
		if (power_save)
			next_ps = (ind_on && !force_sleep) ? PS_STANDBY : PS_SLEEP;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps <= PS_ACTIVE;
		end else begin
			ps <= next_ps;
		end
	end

	// software reset in standby forces sleep until power save ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_sleep <= 1'b0;
		end else if (hw_init || !power_save) begin
			force_sleep <= 1'b0;
		end else if (soft_rst && ps == PS_STANDBY) begin
			force_sleep <= 1'b1;
		end
	end

	// panel drive and supply gating
	always_comb begin
		case (ps)
			PS_ACTIVE: begin
				drive_active = 1'b1;
				osc_run      = 1'b1;
			end
			PS_STANDBY: begin
				drive_active = 1'b0;
				osc_run      = 1'b1;
			end
			PS_SLEEP: begin
				drive_active = 1'b0;
				osc_run      = 1'b0;
			end
			default: begin
				drive_active = 1'b0;
				osc_run      = 1'b0;
			end
		endcase
	end
	assign follower_en  = drive_active & power_ctl[`LCDCD_FOLLOW_BIT];
	assign regulator_en = drive_active & power_ctl[`LCDCD_REGUL_BIT];
	assign booster_en   = drive_active & power_ctl[`LCDCD_BOOST_BIT];

	// pixel level from ram bit, reverse and all-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pixel_drive <= 1'b0;
		end else begin
			pixel_drive <= drive_active & disp_on & (all_on | (ram_bit ^ reverse));
		end
	end

	// blink timer for the static indicator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt  <= 32'h0000_0000;
			blink_fast <= 1'b0;
			blink_slow <= 1'b0;
		end else if (!osc_run) begin
			blink_cnt <= 32'h0000_0000;
		end else begin
			blink_cnt <= (blink_cnt == 32'(SLOW_CYC - 1)) ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
			if (blink_cnt == 32'(FAST_CYC - 1) || blink_cnt == 32'(SLOW_CYC - 1))
				blink_fast <= ~blink_fast;
			if (blink_cnt == 32'(SLOW_CYC - 1))
				blink_slow <= ~blink_slow;
		end
	end

	// indicator terminal runs in standby, stops in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_segment_terminal <= 1'b0;
		end else if (!ind_on || ps == PS_SLEEP) begin
			indicator_segment_terminal <= 1'b0;
		end else begin
			case (ind_mode)
				`LCDCD_IND_FAST:   indicator_segment_terminal <= blink_fast;
				`LCDCD_IND_SLOW:   indicator_segment_terminal <= blink_slow;
				`LCDCD_IND_STEADY: indicator_segment_terminal <= 1'b1;
				default:           indicator_segment_terminal <= 1'b0;
			endcase
		end
	end

	// apb slave: zero wait, read data captured in setup
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign pready    = 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata    <= 32'h0000_0000;
			pslverr   <= 1'b0;
			rd_strobe <= 1'b0;
		end else begin
			rd_strobe <= apb_wr && paddr == `LCDCD_REG_CTRL && pwdata[`LCDCD_CTRL_RDSTB];
			if (apb_setup) begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
				case (paddr)
					`LCDCD_REG_CTRL:   prdata <= 32'h0000_0000;
					`LCDCD_REG_STATUS: prdata <= {20'h0_0000, test_mode, partial_mode, osc_slow,
						rmw, ind_on, all_on, reverse, disp_on, vol_pending, ind_pending, ps};
					`LCDCD_REG_SETUP:  prdata <= {10'h000, scan_reverse, bias_seventh, 2'h0, ind_mode,
						1'b0, power_ctl, 1'b0, reg_ratio, 2'h0, volume};
					`LCDCD_REG_ADDR:   prdata <= {10'h000, start_line, 4'h0, page, column};
					default:           pslverr <= 1'b1;
				endcase
			end
		end
	end

	// checks
	a_vol_load: assert property (@(posedge pclk) disable iff (!presetn)
		(vol_pending && rx_valid && rx_cmd && !hw_init && !soft_rst) |=> (!vol_pending && volume == $past(rx_data[5:0])))
		else $error("volume byte not loaded");
	a_ind_lock: assert property (@(posedge pclk) disable iff (!presetn)
		(ind_pending && rx_valid && rx_cmd && !hw_init && !rd_strobe)
		|=> (!ind_pending && $stable(disp_on) && $stable(column)))
		else $error("indicator register byte ran as command");
	a_rmw_restore: assert property (@(posedge pclk) disable iff (!presetn)
		(rmw && cmd_go && rx_data == `LCDCD_OP_END && !hw_init) |=> (column == $past(rmw_col) && !rmw))
		else $error("end did not restore column");
	a_rmw_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(rmw && rd_strobe && !rx_valid && !hw_init) |=> $stable(column))
		else $error("read advanced column in rmw");
	a_soft_keep_pwr: assert property (@(posedge pclk) disable iff (!presetn)
		(soft_rst && !hw_init) |=> (power_ctl == $past(power_ctl) && volume == `LCDCD_VOL_RST))
		else $error("soft reset changed power field");
	a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(ps == PS_SLEEP) |-> (!osc_run && !follower_en && !booster_en) ##1 !pixel_drive)
		else $error("sleep left circuits running");
	a_standby_ind: assert property (@(posedge pclk) disable iff (!presetn)
		(ps == PS_STANDBY && ind_mode == `LCDCD_IND_STEADY && ind_on) |=> (indicator_segment_terminal || ps != PS_STANDBY))
		else $error("standby stopped indicator");
	a_psave_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(!disp_on && all_on) |=> (ps != PS_ACTIVE && !drive_active))
		else $error("power save not entered");
	a_stby_to_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		(ps == PS_STANDBY && soft_rst && power_save && !hw_init) |=> ##1 (ps == PS_SLEEP || !power_save))
		else $error("reset in standby did not sleep");
	a_normal_pixel: assert property (@(posedge pclk) disable iff (!presetn)
		(drive_active && disp_on && !all_on && !reverse) |=> (pixel_drive == $past(ram_bit)))
		else $error("normal pixel mismatch");
endmodule

// *** tb/lcdcd_host.sv ***
// host model: frames bytes msb first on the serial link
// assumes pclk from the bench; link clock period is 8 pclk
`timescale 1ns/100ps
module lcdcd_host (
	input  wire logic pclk,
	output logic      serial_clk,
	output logic      serial_data,
	output logic      chip_sel_n,
	output logic      cmd_data_select
);
	// idle link: clock still, deselected
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		chip_sel_n = 1'b1;
		cmd_data_select = 1'b1;
	end
	// one byte; low a0 marks a command
	task automatic send(input logic a0, input logic [7:0] b);
		@(posedge pclk);
		chip_sel_n <= 1'b0;
		cmd_data_select <= a0;
		for (int i = 7; i >= 0; i--) begin
			serial_data <= b[i];
			serial_clk <= 1'b0;
			repeat (4) @(posedge pclk);
			serial_clk <= 1'b1;
			repeat (4) @(posedge pclk);
		end
		serial_clk <= 1'b0;
		chip_sel_n <= 1'b1;
		serial_data <= ~b[0]; // released line shows no stale bit
		cmd_data_select <= ~a0;
		repeat (12) @(posedge pclk);
	endtask
endmodule

// *** tb/test_lcd_display_command_decoder.sv ***
// self-checking bench for the lcd command decoder
// assumes lcdcd_host on the link; apb driven here
`timescale 1ns/100ps
module test_lcd_display_command_decoder;
	logic        pclk, presetn, psel, penable, pwrite, hw_reset_n, ram_bit, pready, pslverr;
	logic        sclk, sdat, cs_n, a0, pix, act, orun, oslow, fol, reg_en, boo, b7, scan, ind, part;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  ratio;
	logic [1:0]  duty, mduty;
	logic [5:0]  vol;
	logic [7:0]  col;
	int          bad_count = 0;
	int          tests_run = 0;
	logic [7:0]  f_op [11] = '{8'hA3, 8'hC8, 8'h2E, 8'h2D, 8'h25, 8'hE5, 8'h83, 8'hC7, 8'hA2, 8'h82, 8'hE4};
	logic [9:0]  f_ex [11] = '{10'h200, 10'h300, 10'h360, 10'h3A0, 10'h3B4, 10'h3B6, 10'h3B7, 10'h2B7,
		10'h0B7, 10'h0B6, 10'h0B4};

	lcdcd_top #(.FAST_CYC(8), .SLOW_CYC(16)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_reset_n,
		.serial_clk(sclk), .serial_data(sdat), .chip_sel_n(cs_n), .cmd_data_select(a0), .duty_strap_lo(duty[0]),
		.duty_strap_hi(duty[1]), .ram_bit, .pixel_drive(pix), .drive_active(act), .osc_run(orun), .osc_slow(oslow),
		.follower_en(fol), .regulator_en(reg_en), .booster_en(boo), .bias_seventh(b7), .scan_reverse(scan),
		.reg_ratio(ratio), .volume(vol), .indicator_segment_terminal(ind), .partial_mode(part), .max_duty(mduty),
		.column(col), .page(), .start_line()
	);
	lcdcd_host host (.pclk, .serial_clk(sclk), .serial_data(sdat), .chip_sel_n(cs_n), .cmd_data_select(a0));

	// 50 mhz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// one apb transfer; read data lands in q
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		if (pready !== 1'b1) begin
			bad_count++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// single-byte field commands
	task automatic t_fields();
		chk("straps", 2'h2, mduty);
		for (int i = 0; i < 11; i++) begin
			host.send(1'b0, f_op[i]);
			chk("fields", {22'h0, f_ex[i]}, {22'h0, b7, scan, fol, reg_en, boo, ratio, oslow, part});
		end
	endtask

	// volume pair; the byte after the mode is sent as a command byte and taken as the value
	task automatic t_volume();
		host.send(1'b0, 8'h81);
		host.send(1'b0, 8'hA3);
		chk("vol", 6'h23, vol);
		chk("bias kept", 1'b0, b7);
		host.send(1'b0, 8'h81);
		host.send(1'b0, 8'hFF);
		chk("vol top", 6'h3F, vol);
	endtask

	// reverse and all-on against the ram bit
	task automatic t_pixel();
		host.send(1'b0, 8'hAF);
		host.send(1'b0, 8'hA7);
		chk("rev zero", 1'b1, pix);
		ram_bit <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("rev one", 1'b0, pix);
		host.send(1'b0, 8'hA6);
		chk("norm one", 1'b1, pix);
		ram_bit <= 1'b0;
		host.send(1'b0, 8'hA5);
		chk("all on", 1'b1, pix);
		host.send(1'b0, 8'hA4);
		chk("all off", 1'b0, pix);
	endtask

	// standby, reset into sleep, wake, sleep again
	task automatic t_psave();
		host.send(1'b0, 8'hAD);
		host.send(1'b0, 8'h03);
		chk("ind", 1'b1, ind);
		host.send(1'b0, 8'hA5);
		host.send(1'b0, 8'hAE);
		chk("sb drive", 1'b0, act);
		chk("sb osc", 1'b1, orun);
		chk("sb ind", 1'b1, ind);
		chk("sb vol", 6'h3F, vol);
		host.send(1'b0, 8'h45);
		host.send(1'b0, 8'hB3);
		host.send(1'b0, 8'hF5);
		apb(1'b0, 12'h00C, 32'h0);
		chk("addr set", 32'h0005_0300, q);
		@(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("status sb", 32'h0000_08C1, q);
		host.send(1'b0, 8'hE2);
		chk("sl osc", 1'b0, orun);
		apb(1'b0, 12'h008, 32'h0);
		chk("soft reset", 32'h0000_5000, q);
		@(posedge pclk);
		apb(1'b0, 12'h00C, 32'h0);
		chk("addr rst", 32'h0, q);
		@(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("status sl", 32'h0000_00C2, q);
		host.send(1'b0, 8'hAF);
		host.send(1'b0, 8'hAD);
		host.send(1'b0, 8'h01);
		chk("wake", 1'b1, act);
		q[0] = ind;
		repeat (8) @(posedge pclk);
		chk("blink", !q[0], ind);
		host.send(1'b0, 8'hAC);
		chk("ind off", 1'b0, ind);
		host.send(1'b0, 8'hA4);
		host.send(1'b0, 8'hAE);
		host.send(1'b0, 8'hA5);
		chk("sl drive", 1'b0, act);
		chk("sl osc2", 1'b0, orun);
	endtask

	// column during read-modify-write, while asleep
	task automatic t_rmw();
		host.send(1'b0, 8'h10);
		host.send(1'b0, 8'h05);
		host.send(1'b1, 8'h55);
		chk("col", 8'h06, col);
		host.send(1'b0, 8'hE0);
		host.send(1'b1, 8'hA3);
		chk("rmw wr", 8'h07, col);
		chk("data", 1'b0, b7);
		apb(1'b1, 12'h000, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk("rmw rd", 8'h07, col);
		host.send(1'b0, 8'hEE);
		chk("end", 8'h06, col);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 1'b1, pslverr);
		hw_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		hw_reset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		chk("hw reset", 3'h0, q[14:12]);
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		test_done();
	end

	// main sequence after a three-cycle reset
	initial begin
		presetn = 1'b0;
		hw_reset_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		ram_bit = 1'b0;
		duty = 2'h2;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_fields();
		t_volume();
		t_pixel();
		t_psave();
		t_rmw();
		test_done();
	end
endmodule
